// File: hw/pmr_consts.vh
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH

// ****************************************
// Register numbers on the management link
// ****************************************
`define PMR_REG_CONTROL     5'h00
`define PMR_REG_STATUS      5'h01
`define PMR_REG_ID_HIGH     5'h02
`define PMR_REG_ID_LOW      5'h03
`define PMR_REG_ADVERTISE   5'h04
`define PMR_REG_LP_ABILITY  5'h05
`define PMR_REG_EXPANSION   5'h06
`define PMR_UNMAPPED_DATA   16'hffff

// ****************************************
// Basic control bit positions
// ****************************************
`define PMR_CTL_RESET       15
`define PMR_CTL_LOOPBACK    14
`define PMR_CTL_SPEED       13
`define PMR_CTL_AN_ENABLE   12
`define PMR_CTL_POWER_DOWN  11
`define PMR_CTL_ISOLATE     10
`define PMR_CTL_AN_RESTART  9
`define PMR_CTL_DUPLEX      8
`define PMR_CTL_COL_TEST    7

// ****************************************
// Basic status bit positions and fixed bits
// ****************************************
`define PMR_STS_AN_DONE     5
`define PMR_STS_RFAULT      4
`define PMR_STS_LINK        2
`define PMR_STS_JABBER      1
`define PMR_STS_FIXED       16'h7809

// ****************************************
// Advertisement bit positions and resets
// ****************************************
`define PMR_ADV_RFAULT      13
`define PMR_ADV_PAUSE_HI    11
`define PMR_ADV_PAUSE_LO    10
`define PMR_ADV_100FD       8
`define PMR_ADV_100HD       7
`define PMR_ADV_10FD        6
`define PMR_ADV_10HD        5
`define PMR_ADV_SEL_HI      4
`define PMR_ADV_SEL_RESET   5'h01
`define PMR_ADV_PAUSE_RESET 2'h0
`define PMR_ADV_100HD_RESET 1'b1
`define PMR_ISOLATE_MODE    3'h6

// ****************************************
// Serial frame layout
// ****************************************
`define PMR_PREAMBLE_BITS   6'd32
`define PMR_HEADER_BITS     4'd12
`define PMR_DATA_BITS       5'd16
`define PMR_OP_READ         2'h2
`define PMR_OP_WRITE        2'h1

`endif

// File: hw/pmr_register_set.v
`timescale 1ns/1ns
`include "pmr_consts.vh"

module pmr_register_set (
    input  wire        clock,
    input  wire        srst,
    input  wire        mdc,
    input  wire        mdi,
    input  wire [4:0]  phy_address,
    input  wire [2:0]  strap_mode_field,
    input  wire [15:0] oui_upper_input,
    input  wire [15:0] oui_lower_input,
    input  wire        link_up,
    input  wire        remote_fault_event,
    input  wire        jabber_event,
    input  wire        an_complete,
    input  wire [15:0] lp_ability,
    input  wire        page_rx_event,
    input  wire        pd_fault_event,
    input  wire        lp_an_able,
    output reg         mdo,
    output reg         mdo_oe_n,
    output reg         loopback_en,
    output reg         power_down,
    output reg         isolate,
    output reg         an_enable,
    output reg         speed_100,
    output reg         full_duplex,
    output reg         col_test_en,
    output reg         an_restart,
    output reg         soft_reset,
    output reg  [15:0] advertise_word
);

    // ****************************************
    // Frame engine states
    // ****************************************
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_HEAD  = 3'd2;
    localparam [2:0] ST_RTA   = 3'd3;
    localparam [2:0] ST_RDATA = 3'd4;
    localparam [2:0] ST_WTA   = 3'd5;
    localparam [2:0] ST_WDATA = 3'd6;

    // ****************************************
    // Declarations
    // ****************************************
    reg         mdc_s1_reg;
    reg         mdc_s2_reg;
    reg         mdc_s3_reg;
    reg         mdi_s1_reg;
    reg         mdi_s2_reg;
    reg  [2:0]  state_reg;
    reg  [5:0]  pre_cnt_reg;
    reg  [4:0]  bit_cnt_reg;
    reg  [11:0] head_reg;
    reg  [15:0] shift_reg;
    reg  [15:0] ctl_reg;
    reg  [15:0] id_high_reg;
    reg  [15:0] id_low_reg;
    reg  [15:0] adv_reg;
    reg         rfault_lat_reg;
    reg         jabber_lat_reg;
    reg         link_lat_reg;
    reg         page_lat_reg;
    reg         pdf_lat_reg;
    reg  [15:0] ctl_rst;
    reg  [15:0] adv_rst;
    reg  [15:0] status_word;
    reg  [15:0] read_data;
    reg  [15:0] ctl_next;
    reg  [15:0] adv_next;
    reg         wr_commit;
    reg         rd_status;
    reg         rd_expand;
    wire        mdc_rise;
    wire        bit_in;
    wire [4:0]  head_reg_addr;

    assign mdc_rise      = mdc_s2_reg & ~mdc_s3_reg;
    assign bit_in        = mdi_s2_reg;
    assign head_reg_addr = head_reg[4:0];

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Second stage feeds edge detect; first stage touched by nothing else
    always @(posedge clock) begin
        if (srst) begin
            mdc_s1_reg <= 1'b0;
            mdc_s2_reg <= 1'b0;
            mdc_s3_reg <= 1'b0;
            mdi_s1_reg <= 1'b1;
            mdi_s2_reg <= 1'b1;
        end else begin
            mdc_s1_reg <= mdc;
            mdc_s2_reg <= mdc_s1_reg;
            mdc_s3_reg <= mdc_s2_reg;
            mdi_s1_reg <= mdi;
            mdi_s2_reg <= mdi_s1_reg;
        end
    end

    // ****************************************
    // Strap-derived reset values
    // ****************************************
    // Mode bit 2 enables negotiation, bit 1 picks 100M, bit 0 full duplex
    always @* begin
        ctl_rst = 16'h0000;
        ctl_rst[`PMR_CTL_SPEED]     = strap_mode_field[1];
        ctl_rst[`PMR_CTL_AN_ENABLE] = strap_mode_field[2];
        ctl_rst[`PMR_CTL_DUPLEX]    = strap_mode_field[0];
        ctl_rst[`PMR_CTL_ISOLATE]   = (strap_mode_field == `PMR_ISOLATE_MODE);
        adv_rst = 16'h0000;
        adv_rst[`PMR_ADV_SEL_HI:0]  = `PMR_ADV_SEL_RESET;
        adv_rst[`PMR_ADV_PAUSE_HI:`PMR_ADV_PAUSE_LO] = `PMR_ADV_PAUSE_RESET;
        adv_rst[`PMR_ADV_100HD]     = `PMR_ADV_100HD_RESET;
        adv_rst[`PMR_ADV_100FD]     = strap_mode_field[0] &
                                      (strap_mode_field[1] | strap_mode_field[2]);
        adv_rst[`PMR_ADV_10FD]      = strap_mode_field[0];
        adv_rst[`PMR_ADV_10HD]      = ~strap_mode_field[1] | strap_mode_field[2];
    end

    // ****************************************
    // Status word and read multiplexer
    // ****************************************
    always @* begin
        status_word = `PMR_STS_FIXED;
        status_word[`PMR_STS_AN_DONE] = an_complete;
        status_word[`PMR_STS_RFAULT]  = rfault_lat_reg;
        status_word[`PMR_STS_LINK]    = link_lat_reg;
        status_word[`PMR_STS_JABBER]  = jabber_lat_reg;
        if (head_reg_addr == `PMR_REG_CONTROL) begin
            read_data = ctl_reg;
        end else if (head_reg_addr == `PMR_REG_STATUS) begin
            read_data = status_word;
        end else if (head_reg_addr == `PMR_REG_ID_HIGH) begin
            read_data = id_high_reg;
        end else if (head_reg_addr == `PMR_REG_ID_LOW) begin
            read_data = id_low_reg;
        end else if (head_reg_addr == `PMR_REG_ADVERTISE) begin
            read_data = adv_reg;
        end else if (head_reg_addr == `PMR_REG_LP_ABILITY) begin
            read_data = lp_ability;
        end else if (head_reg_addr == `PMR_REG_EXPANSION) begin
            read_data = {11'h000, pdf_lat_reg, 2'h0, page_lat_reg, lp_an_able};
        end else begin
            read_data = `PMR_UNMAPPED_DATA;
        end
    end

    // ****************************************
    // Frame engine, one step per rising MDC
    // ****************************************
    // Snapshot taken at the first turnaround bit, so later events land in the next read
    always @(posedge clock) begin
        if (srst) begin
            state_reg   <= ST_IDLE;
            pre_cnt_reg <= 6'd0;
            bit_cnt_reg <= 5'd0;
            head_reg    <= 12'h000;
            shift_reg   <= 16'h0000;
            mdo         <= 1'b1;
            mdo_oe_n    <= 1'b1;
        end else if (mdc_rise) begin
            case (state_reg)
                ST_IDLE: begin
                    mdo_oe_n <= 1'b1;
                    if (bit_in) begin
                        if (pre_cnt_reg != `PMR_PREAMBLE_BITS) begin
                            pre_cnt_reg <= pre_cnt_reg + 6'd1;
                        end
                    end else begin
                        if (pre_cnt_reg == `PMR_PREAMBLE_BITS) begin
                            state_reg <= ST_START;
                        end
                        pre_cnt_reg <= 6'd0;
                    end
                end
                ST_START: begin
                    bit_cnt_reg <= 5'd0;
                    state_reg   <= bit_in ? ST_HEAD : ST_IDLE;
                end
                ST_HEAD: begin
                    head_reg    <= {head_reg[10:0], bit_in};
                    bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    if (bit_cnt_reg == {1'b0, `PMR_HEADER_BITS} - 5'd1) begin
                        bit_cnt_reg <= 5'd0;
                        state_reg   <= ST_IDLE;
                        if (head_reg[8:4] == phy_address) begin
                            if (head_reg[10:9] == `PMR_OP_READ) begin
                                state_reg <= ST_RTA;
                            end else if (head_reg[10:9] == `PMR_OP_WRITE) begin
                                state_reg <= ST_WTA;
                            end
                        end
                    end
                end
                ST_RTA: begin
                    // Second turnaround bit: drive zero
                    shift_reg <= read_data;
                    mdo       <= 1'b0;
                    mdo_oe_n  <= 1'b0;
                    state_reg <= ST_RDATA;
                end
                ST_RDATA: begin
                    if (bit_cnt_reg == `PMR_DATA_BITS) begin
                        mdo         <= 1'b1;
                        mdo_oe_n    <= 1'b1;
                        bit_cnt_reg <= 5'd0;
                        state_reg   <= ST_IDLE;
                    end else begin
                        mdo         <= shift_reg[15];
                        shift_reg   <= {shift_reg[14:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                ST_WTA: begin
                    bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    if (bit_cnt_reg == 5'd1) begin
                        bit_cnt_reg <= 5'd0;
                        state_reg   <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    shift_reg   <= {shift_reg[14:0], bit_in};
                    bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    if (bit_cnt_reg == `PMR_DATA_BITS - 5'd1) begin
                        bit_cnt_reg <= 5'd0;
                        state_reg   <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Access strobes
    // ****************************************
    always @* begin
        wr_commit = mdc_rise && (state_reg == ST_WDATA) &&
                    (bit_cnt_reg == `PMR_DATA_BITS - 5'd1);
        rd_status = mdc_rise && (state_reg == ST_RTA) &&
                    (head_reg_addr == `PMR_REG_STATUS);
        rd_expand = mdc_rise && (state_reg == ST_RTA) &&
                    (head_reg_addr == `PMR_REG_EXPANSION);
    end

    // ****************************************
    // Writable register next values
    // ****************************************
    // Self-clearing bits never store a one; at commit shift_reg lags the word by one bit
    always @* begin
        ctl_next = ctl_reg;
        ctl_next[`PMR_CTL_RESET]      = 1'b0;
        ctl_next[`PMR_CTL_AN_RESTART] = 1'b0;
        adv_next = adv_reg;
        if (wr_commit && head_reg_addr == `PMR_REG_CONTROL) begin
            ctl_next[`PMR_CTL_LOOPBACK]   = shift_reg[`PMR_CTL_LOOPBACK - 1];
            ctl_next[`PMR_CTL_SPEED]      = shift_reg[`PMR_CTL_SPEED - 1];
            ctl_next[`PMR_CTL_AN_ENABLE]  = shift_reg[`PMR_CTL_AN_ENABLE - 1];
            ctl_next[`PMR_CTL_POWER_DOWN] = shift_reg[`PMR_CTL_POWER_DOWN - 1];
            ctl_next[`PMR_CTL_ISOLATE]    = shift_reg[`PMR_CTL_ISOLATE - 1];
            ctl_next[`PMR_CTL_DUPLEX]     = shift_reg[7];
            ctl_next[`PMR_CTL_COL_TEST]   = shift_reg[6];
        end
        if (wr_commit && head_reg_addr == `PMR_REG_ADVERTISE) begin
            adv_next = {2'b00, shift_reg[`PMR_ADV_RFAULT - 1], 1'b0, shift_reg[10:9], 1'b0,
                        shift_reg[7:4], shift_reg[3:0], bit_in};
        end
    end

    // ****************************************
    // Register bank and pulse outputs
    // ****************************************
    // Soft reset returns control and advertisement to strap defaults
    always @(posedge clock) begin
        if (srst) begin
            ctl_reg     <= ctl_rst;
            adv_reg     <= adv_rst;
            id_high_reg <= oui_upper_input;
            id_low_reg  <= oui_lower_input;
            an_restart  <= 1'b0;
            soft_reset  <= 1'b0;
        end else begin
            an_restart <= 1'b0;
            soft_reset <= 1'b0;
            if (wr_commit && head_reg_addr == `PMR_REG_CONTROL && shift_reg[14]) begin
                ctl_reg    <= ctl_rst;
                adv_reg    <= adv_rst;
                soft_reset <= 1'b1;
            end else begin
                ctl_reg <= ctl_next;
                adv_reg <= adv_next;
                if (wr_commit && head_reg_addr == `PMR_REG_CONTROL && shift_reg[8]) begin
                    an_restart <= 1'b1;
                end
            end
            if (wr_commit && head_reg_addr == `PMR_REG_ID_HIGH) begin
                id_high_reg <= {shift_reg[14:0], bit_in};
            end
            if (wr_commit && head_reg_addr == `PMR_REG_ID_LOW) begin
                id_low_reg <= {shift_reg[14:0], bit_in};
            end
        end
    end

    // ****************************************
    // Latched status bits
    // ****************************************
    // A new event in the read cycle wins, so nothing is lost
    always @(posedge clock) begin
        if (srst || soft_reset) begin
            rfault_lat_reg <= 1'b0;
            jabber_lat_reg <= 1'b0;
            link_lat_reg   <= 1'b0;
            page_lat_reg   <= 1'b0;
            pdf_lat_reg    <= 1'b0;
        end else begin
            rfault_lat_reg <= remote_fault_event | (rfault_lat_reg & ~rd_status);
            jabber_lat_reg <= jabber_event | (jabber_lat_reg & ~rd_status);
            link_lat_reg   <= link_up & (link_lat_reg | rd_status);
            page_lat_reg   <= page_rx_event | (page_lat_reg & ~rd_expand);
            pdf_lat_reg    <= pd_fault_event | (pdf_lat_reg & ~rd_expand);
        end
    end

    // ****************************************
    // Mode outputs
    // ****************************************
    // Manual speed and duplex are masked while negotiation owns them
    always @(posedge clock) begin
        if (srst) begin
            loopback_en    <= 1'b0;
            power_down     <= 1'b0;
            isolate        <= 1'b0;
            an_enable      <= 1'b0;
            speed_100      <= 1'b0;
            full_duplex    <= 1'b0;
            col_test_en    <= 1'b0;
            advertise_word <= 16'h0000;
        end else begin
            loopback_en    <= ctl_reg[`PMR_CTL_LOOPBACK];
            power_down     <= ctl_reg[`PMR_CTL_POWER_DOWN];
            isolate        <= ctl_reg[`PMR_CTL_ISOLATE];
            an_enable      <= ctl_reg[`PMR_CTL_AN_ENABLE];
            speed_100      <= ctl_reg[`PMR_CTL_SPEED] & ~ctl_reg[`PMR_CTL_AN_ENABLE];
            full_duplex    <= ctl_reg[`PMR_CTL_DUPLEX] & ~ctl_reg[`PMR_CTL_AN_ENABLE];
            col_test_en    <= ctl_reg[`PMR_CTL_COL_TEST];
            advertise_word <= adv_reg;
        end
    end

endmodule // pmr_register_set

// File: sim/phy_management_register_set_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %h want %h", $time, g, e); end end
module phy_management_register_set_tb_top;
    // ****************************************
    // Stimulus, reference model and checks
    // ****************************************
    logic        clock = 0, srst = 1, link_up = 1, rf_ev = 0, jab_ev = 0, an_done = 0, lp_able;
    logic [2:0]  strap;
    logic [15:0] oui_a, oui_b, lp_word, rd;
    wire         mdc, mdi, mdo, mdo_oe_n, loopback_en, power_down, isolate, an_enable;
    wire         speed_100, full_duplex, col_test_en, an_restart, soft_reset;
    wire [15:0]  advertise_word;
    int          failures = 0, checks_done = 0, cycles = 0, restarts = 0, softs = 0, seed = 97;
    int          ctl, adv, ctl_def, adv_def, id3, i;
    int          ex[5];
    int          ct[3] = '{16'h4880, 16'h2100, 16'h1200};
    int          rq[$] = {5, 6, 7, 15};

    pmr_register_set DUT (.clock(clock), .srst(srst), .mdc(mdc), .mdi(mdi), .phy_address(5'h01),
        .strap_mode_field(strap), .oui_upper_input(oui_a), .oui_lower_input(oui_b), .link_up(link_up),
        .remote_fault_event(rf_ev), .jabber_event(jab_ev), .an_complete(an_done), .lp_ability(lp_word),
        .page_rx_event(1'b0), .pd_fault_event(1'b0), .lp_an_able(lp_able), .mdo(mdo), .mdo_oe_n(mdo_oe_n),
        .loopback_en(loopback_en), .power_down(power_down), .isolate(isolate), .an_enable(an_enable),
        .speed_100(speed_100), .full_duplex(full_duplex), .col_test_en(col_test_en),
        .an_restart(an_restart), .soft_reset(soft_reset), .advertise_word(advertise_word));
    pmr_smc_model u_smc (.mdc(mdc), .mdi(mdi), .mdo(mdo), .mdo_oe_n(mdo_oe_n));

    always #2 clock = ~clock;
    // Pulse counters and hang guard; a full run needs about 78000 cycles
    always @(posedge clock) begin
        cycles++;
        if (an_restart === 1'b1) restarts++;
        if (soft_reset === 1'b1) softs++;
        if (cycles == 99000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic wr(input int r, input int v);
        u_smc.xfer(5'h01, 2'b01, 5'(r), 16'(v), rd);
    endtask
    task automatic rd_chk(input int r, input int e);
        u_smc.xfer(5'h01, 2'b10, 5'(r), 16'h0, rd);
        `CHK(rd, 16'(e))
    endtask
    task automatic port_chk();
        `CHK({loopback_en, power_down, isolate, an_enable, col_test_en}, 5'({ctl[14], ctl[11], ctl[10], ctl[12], ctl[7]}))
        `CHK({speed_100, full_duplex}, 2'({ctl[13] & ~ctl[12], ctl[8] & ~ctl[12]}))
        `CHK(advertise_word, 16'(adv))
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        strap = 3'($random(seed));
        oui_a = 16'($random(seed));
        oui_b = 16'($random(seed));
        lp_word = 16'($random(seed));
        lp_able = 1'($random(seed));
        ctl_def = 32'({strap[1], strap[2], 1'b0, strap == 3'h6, 1'b0, strap[0]}) << 8;
        adv_def = 32'({strap[0] & (strap[1] | strap[2]), 1'b1, strap[0], ~strap[1] | strap[2], 5'h01});
        ctl = ctl_def;
        adv = adv_def;
        ex = '{ctl_def, 0, oui_a, oui_b, adv_def};
        repeat (12) @(posedge clock);
        #1 srst = 0;
        repeat (6) @(posedge clock);
        #1 port_chk();
        for (i = 0; i < 5; i++) if (i != 1) rd_chk(i, ex[i]);
        // Link bit latched low from reset, negotiation not yet complete
        rd_chk(1, 16'h7809);
        // Latched events, then live values after the read
        @(posedge clock);
        #1 {jab_ev, rf_ev, link_up, an_done} = 4'b1101;
        @(posedge clock);
        #1 {jab_ev, rf_ev, link_up} = 3'b001;
        rd_chk(1, 16'h783b);
        rd_chk(1, 16'h782d);
        // Every pause code with random abilities; reserved bits written as zero
        for (i = 0; i < 4; i++) begin
            adv = (32'($random(seed)) & 16'h21ff) | (i << 10);
            wr(4, adv);
            port_chk();
        end
        rd_chk(4, adv);
        for (i = 0; i < 3; i++) begin
            wr(0, ct[i]);
            ctl = ct[i] & 16'hfdff;
            rd_chk(0, ctl);
            port_chk();
        end
        `CHK(restarts, 1)
        wr(1, 16'h0000);
        rd_chk(1, 16'h782d);
        foreach (rq[j]) rd_chk(rq[j], rq[j] == 5 ? lp_word : rq[j] == 6 ? lp_able : 16'hffff);
        id3 = 16'($random(seed));
        wr(3, id3);
        u_smc.xfer(5'h02, 2'b01, 5'h03, 16'h0, rd); // Another device's address
        rd_chk(3, id3);
        wr(0, 16'h8000);
        ctl = ctl_def;
        adv = adv_def;
        rd_chk(0, ctl);
        rd_chk(4, adv);
        port_chk();
        `CHK(softs, 1)
        end_of_test();
    end
endmodule // phy_management_register_set_tb_top

// File: sim/pmr_register_set_assertions.sv
`timescale 1ns/1ns
module pmr_register_set_assertions (
    input wire        clock,
    input wire        srst,
    input wire        mdo,
    input wire        mdo_oe_n,
    input wire        an_enable,
    input wire        speed_100,
    input wire        full_duplex,
    input wire        an_restart,
    input wire        soft_reset,
    input wire [15:0] advertise_word
);
    // ****************************************
    // Serial answer and control outputs
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Device takes the wire for a read answer
    sequence s_drive_start;
        $fell(mdo_oe_n);
    endsequence

    a_ta_zero_bit: assert property (s_drive_start |-> !mdo)
        else $error("turnaround bit not driven low");
    a_drive_hold: assert property (s_drive_start |-> !mdo_oe_n [*8])
        else $error("answer drive dropped early");
    a_release_high: assert property (mdo_oe_n |-> mdo)
        else $error("data out not high while released");
    a_restart_pulse: assert property (an_restart |=> !an_restart)
        else $error("restart not a single pulse");
    a_soft_pulse: assert property (soft_reset |=> !soft_reset)
        else $error("soft reset not a single pulse");
    a_soft_alone: assert property (soft_reset |-> !an_restart)
        else $error("restart issued with soft reset");
    a_speed_gated: assert property (an_enable |-> !speed_100)
        else $error("manual speed used under auto-negotiation");
    a_duplex_gated: assert property (an_enable |-> !full_duplex)
        else $error("manual duplex used under auto-negotiation");
    a_adv_next_page: assert property (advertise_word[15:14] == 2'b00)
        else $error("next page or reserved advertisement bit set");
    a_adv_reserved: assert property (advertise_word[12] == 1'b0 && advertise_word[9] == 1'b0)
        else $error("reserved advertisement bit set");
endmodule // pmr_register_set_assertions

bind pmr_register_set pmr_register_set_assertions u_chk (.clock(clock), .srst(srst), .mdo(mdo),
    .mdo_oe_n(mdo_oe_n), .an_enable(an_enable), .speed_100(speed_100), .full_duplex(full_duplex),
    .an_restart(an_restart), .soft_reset(soft_reset), .advertise_word(advertise_word));

// File: sim/pmr_smc_model.sv
`timescale 1ns/1ns
module pmr_smc_model (
    output logic mdc,
    output wire  mdi,
    input  wire  mdo,
    input  wire  mdo_oe_n
);
    // ****************************************
    // Management controller on the serial link
    // ****************************************
    logic drv;
    initial begin
        mdc = 1'b0; // Link clock stands still between frames
        drv = 1'b1;
    end
    // Open-drain wire with pull-up, both parties resolved
    assign mdi = drv & (mdo_oe_n | mdo);

    // One link clock period; sampled just before the rise, where the device bit has settled
    task automatic bit_cycle(input logic b, output logic s);
        drv = b;
        #80 s = mdi;
        mdc = 1'b1;
        #80 mdc = 1'b0;
    endtask

    // Whole frame: preamble, start, op, addresses, turnaround and 16 data bits
    task automatic xfer(input logic [4:0] pa, input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        logic        s;
        f = {32'hffffffff, 2'b01, op, pa, ra, (op == 2'b01) ? {2'b10, wd} : 18'h3ffff};
        for (int i = 63; i >= 0; i--) begin
            bit_cycle(f[i], s);
            rd = {rd[14:0], s};
        end
        bit_cycle(1'b1, s); // Idle cycle after the frame; a write has already committed on the last data bit's rise
    endtask
endmodule // pmr_smc_model
